// ### inc/frac_mac_pkg.sv
// shared types and constants of the fractional multiply-accumulate datapath
`default_nettype none

package frac_mac_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ACC_WIDTH   = 64;
    localparam int WORD_WIDTH  = 32;
    localparam int HALF_WIDTH  = 16;
    localparam int ACC_COUNT   = 4;
    localparam int ACC_SEL_W   = 2;

    // ----------------------------------------------------------------
    // fixed-point corner values
    // ----------------------------------------------------------------
    localparam logic [15:0] Q15_NEG_ONE = 16'h8000;
    localparam logic [31:0] Q31_NEG_ONE = 32'h8000_0000;
    localparam logic [31:0] Q31_MAX     = 32'h7fff_ffff;
    localparam logic [63:0] Q31_MAX_ACC = 64'h0000_0000_7fff_ffff;
    localparam logic [63:0] Q31_MIN_ACC = 64'hffff_ffff_8000_0000;
    localparam logic [63:0] Q63_MAX     = 64'h7fff_ffff_ffff_ffff;
    localparam logic [63:0] Q63_MIN     = 64'h8000_0000_0000_0000;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [63:0] ACC_RESET   = 64'h0000_0000_0000_0000;

    // ----------------------------------------------------------------
    // operations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP,
        OP_Q15_PAIR_DOT_ADD,
        OP_Q15_PAIR_DOT_SUB,
        OP_COMPLEX_MUL_STEP,
        OP_Q31_LONG_DOT_ADD,
        OP_Q31_LONG_DOT_SUB,
        OP_Q15_MAC_LEFT,
        OP_Q15_MAC_RIGHT,
        OP_Q15_MAC_SAT_LEFT,
        OP_Q15_MAC_SAT_RIGHT,
        OP_SIGNED_MUL,
        OP_UNSIGNED_MUL,
        OP_SIGNED_MUL_ADD,
        OP_UNSIGNED_MUL_ADD,
        OP_SIGNED_MUL_SUB,
        OP_UNSIGNED_MUL_SUB,
        OP_ACC_LOAD
    } mac_op_t;

    // one decoded instruction from the pipeline
    typedef struct packed {
        logic                 valid;
        mac_op_t              op;
        logic [ACC_SEL_W-1:0] accumulatorSelect;
        logic [31:0]          srcA;
        logic [31:0]          srcB;
    } mac_req_t;

    // one retired accumulator write
    typedef struct packed {
        logic                 valid;
        logic [ACC_SEL_W-1:0] accumulatorSelect;
        logic [63:0]          value;
    } mac_rsp_t;

    typedef logic [ACC_COUNT-1:0][63:0] acc_bank_t;

endpackage

`default_nettype wire

// ### verilog/fractional_mac_datapath.sv
// fractional multiply-accumulate datapath with four 64-bit accumulators
//
// Contract
// - q15 pair dot add: two shifted Q31 products sign-extended, summed, added
// - q15 pair dot sub: same sum of sign-extended products, subtracted from accumulator
// - pair dot products clamp each minus-one-squared product to Q31 maximum
// - complex step: high product minus low product, added to accumulator
// - complex step products saturate to Q31 maximum on minus one squared
// - q31 long dot add: Q63 product, minus-one-squared saturates, added
// - q31 long dot sub: same saturated Q63 product subtracted from accumulator
// - long dot results saturate to 64-bit maximum or minimum on overflow
// - q15 mac: product sign-extended to accumulator width and added
// - q15 mac products saturate to Q31 maximum on minus one squared
// - saturating q15 mac clamps accumulator to Q31 range on overflow
// - base multiply, multiply-add and multiply-sub may target any accumulator
`default_nettype none

module fractional_mac_datapath
    import frac_mac_pkg::*;
(
    // clock and reset
    input  wire logic      mclk,
    input  wire logic      rst,

    // decoded instruction from the pipeline
    input  wire mac_req_t  req,

    // accumulator write result
    output var mac_rsp_t   rsp,

    // architectural accumulators
    output var acc_bank_t  accBank
);

    // ----------------------------------------------------------------
    // product helpers
    // ----------------------------------------------------------------

    // Q15 x Q15 into Q31 with the minus-one corner clamped
    function automatic logic [31:0] q15Prod(
        input logic [15:0] a,
        input logic [15:0] b
    );
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        if (a == Q15_NEG_ONE && b == Q15_NEG_ONE) begin
            q15Prod = Q31_MAX;
        end else begin
            q15Prod = {p[30:0], 1'b0};
        end
    endfunction

    // Q31 x Q31 into Q63 with the minus-one corner clamped
    function automatic logic [63:0] q31Prod(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic signed [63:0] p;
        p = $signed(a) * $signed(b);
        if (a == Q31_NEG_ONE && b == Q31_NEG_ONE) begin
            q31Prod = Q63_MAX;
        end else begin
            q31Prod = {p[62:0], 1'b0};
        end
    endfunction

    // sign extension of a Q31 word to accumulator width
    function automatic logic [63:0] ext32(
        input logic [31:0] x
    );
        ext32 = {{32{x[31]}}, x};
    endfunction

    // clamp a 65-bit sum to the 64-bit accumulator range
    function automatic logic [63:0] sat64(
        input logic [64:0] s
    );
        if (s[64] != s[63]) begin
            sat64 = s[64] ? Q63_MIN : Q63_MAX;
        end else begin
            sat64 = s[63:0];
        end
    endfunction

    // clamp a 65-bit sum to the Q31 range held at accumulator width
    function automatic logic [63:0] satQ31(
        input logic [64:0] s
    );
        if (s[64:31] == {34{1'b0}} || s[64:31] == {34{1'b1}}) begin
            satQ31 = s[63:0];
        end else begin
            satQ31 = s[64] ? Q31_MIN_ACC : Q31_MAX_ACC;
        end
    endfunction

    // ----------------------------------------------------------------
    // accumulator state
    // ----------------------------------------------------------------
    acc_bank_t  acc_q;
    acc_bank_t  acc_d;
    mac_rsp_t   rsp_q;
    mac_rsp_t   rsp_d;

    // ----------------------------------------------------------------
    // operand split
    // ----------------------------------------------------------------
    wire logic [15:0] aHi = req.srcA[31:16];
    wire logic [15:0] aLo = req.srcA[15:0];
    wire logic [15:0] bHi = req.srcB[31:16];
    wire logic [15:0] bLo = req.srcB[15:0];

    // the selected accumulator; any of the four is a legal target
    wire logic [63:0] accCur = acc_q[req.accumulatorSelect];

    // ----------------------------------------------------------------
    // Q15 products
    // ----------------------------------------------------------------
    wire logic [31:0] prodHi = q15Prod(aHi, bHi);
    wire logic [31:0] prodLo = q15Prod(aLo, bLo);

    wire logic isLeft = (req.op == OP_Q15_MAC_LEFT) ||
                        (req.op == OP_Q15_MAC_SAT_LEFT);

    // left forms read upper halfwords, right forms lower ones
    wire logic [31:0] prodSel = isLeft ? prodHi : prodLo;

    // the pair sum is formed at full width so that two clamped
    // maxima cannot wrap before reaching the accumulator
    wire logic [63:0] dotSum  = ext32(prodHi) + ext32(prodLo);
    wire logic [63:0] cplxDif = ext32(prodHi) - ext32(prodLo);

    // ----------------------------------------------------------------
    // Q31 long product
    // ----------------------------------------------------------------
    wire logic [63:0] longProd = q31Prod(req.srcA, req.srcB);

    wire logic [64:0] longAdd = {accCur[63], accCur} +
                                {longProd[63], longProd};
    wire logic [64:0] longSub = {accCur[63], accCur} -
                                {longProd[63], longProd};

    // ----------------------------------------------------------------
    // Q15 multiply-accumulate
    // ----------------------------------------------------------------
    wire logic [63:0] macExt  = ext32(prodSel);
    wire logic [64:0] macWide = {accCur[63], accCur} +
                                {macExt[63], macExt};

    // ----------------------------------------------------------------
    // base integer multiply
    // ----------------------------------------------------------------
    wire logic signed [63:0] smul = $signed(req.srcA) * $signed(req.srcB);
    wire logic        [63:0] umul = {32'h0000_0000, req.srcA} *
                                    {32'h0000_0000, req.srcB};

    // ----------------------------------------------------------------
    // result selection
    // ----------------------------------------------------------------
    logic [63:0] result;
    logic        writes;

    always_comb begin
        result = accCur;
        writes = 1'b1;
        case (req.op)
            OP_Q15_PAIR_DOT_ADD: begin
                result = accCur + dotSum;
            end
            OP_Q15_PAIR_DOT_SUB: begin
                result = accCur - dotSum;
            end
            OP_COMPLEX_MUL_STEP: begin
                result = accCur + cplxDif;
            end
            OP_Q31_LONG_DOT_ADD: begin
                result = sat64(longAdd);
            end
            OP_Q31_LONG_DOT_SUB: begin
                result = sat64(longSub);
            end
            OP_Q15_MAC_LEFT, OP_Q15_MAC_RIGHT: begin
                result = macWide[63:0];
            end
            OP_Q15_MAC_SAT_LEFT, OP_Q15_MAC_SAT_RIGHT: begin
                result = satQ31(macWide);
            end
            OP_SIGNED_MUL: begin
                result = smul;
            end
            OP_UNSIGNED_MUL: begin
                result = umul;
            end
            OP_SIGNED_MUL_ADD: begin
                result = accCur + smul;
            end
            OP_UNSIGNED_MUL_ADD: begin
                result = accCur + umul;
            end
            OP_SIGNED_MUL_SUB: begin
                result = accCur - smul;
            end
            OP_UNSIGNED_MUL_SUB: begin
                result = accCur - umul;
            end
            OP_ACC_LOAD: begin
                result = {req.srcA, req.srcB};
            end
            default: begin
                writes = 1'b0;
            end
        endcase
    end

    wire logic doWrite = req.valid && writes;

    // ----------------------------------------------------------------
    // accumulator update, one entry per accumulator
    // ----------------------------------------------------------------
    for (genvar i = 0; i < ACC_COUNT; i++) begin : g_acc
        wire logic hit = doWrite &&
                         (req.accumulatorSelect == ACC_SEL_W'(i));
        assign acc_d[i] = hit ? result : acc_q[i];
    end

    always_comb begin
        rsp_d.valid             = doWrite;
        rsp_d.accumulatorSelect = req.accumulatorSelect;
        rsp_d.value             = result;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // one instruction per cycle; a back-to-back op on the same
    // accumulator sees the previous result since acc_q is read directly
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_q <= {ACC_COUNT{ACC_RESET}};
            rsp_q <= '0;
        end else begin
            acc_q <= acc_d;
            rsp_q <= rsp_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign accBank = acc_q;
    assign rsp     = rsp_q;

endmodule

`default_nettype wire

// ### testbench/pipeline_model.sv
// pipeline model presenting decoded instructions to the datapath
`default_nettype none
module pipeline_model
    import frac_mac_pkg::*;
(
    // clock
    input  wire logic mclk,
    // decoded instruction
    output var mac_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    // request holds until the next call, so callers end a burst with an idle issue
    task automatic issue(input logic v, input mac_op_t op, input logic [1:0] sel,
                         input logic [31:0] a, input logic [31:0] b);
        @(posedge mclk);
        #1 req <= '{v, op, sel, a, b};
    endtask
endmodule
`default_nettype wire

// ### testbench/frac_mac_assertions.sv
// concurrent checks on the datapath ports
`default_nettype none
module frac_mac_assertions
    import frac_mac_pkg::*;
(
    // clock and reset
    input  wire logic      mclk,
    input  wire logic      rst,
    // watched ports
    input  wire mac_req_t  req,
    input  wire mac_rsp_t  rsp,
    input  wire acc_bank_t accBank
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic taken = req.valid && req.op != OP_NOP;
    rsp_on_issue_a: assert property (taken |=> rsp.valid &&
        rsp.accumulatorSelect == $past(req.accumulatorSelect)) else $error("missing write");
    no_idle_write_a: assert property (!taken |=> !rsp.valid && $stable(accBank))
        else $error("write without issue");
    bank_tracks_a: assert property (rsp.valid |->
        accBank[rsp.accumulatorSelect] == rsp.value)
        else $error("bank differs from reported value");
    signed_product_a: assert property (taken && req.op == OP_SIGNED_MUL |=>
        $signed(rsp.value) == $signed($past(req.srcA)) * $signed($past(req.srcB)))
        else $error("signed product wrong");
    unsigned_product_a: assert property (taken && req.op == OP_UNSIGNED_MUL |=>
        rsp.value == $past(req.srcA) * $past(req.srcB)) else $error("unsigned product wrong");
    long_corner_a: assert property (taken && req.op == OP_Q31_LONG_DOT_ADD &&
        req.srcA == Q31_NEG_ONE && req.srcB == Q31_NEG_ONE && accBank[req.accumulatorSelect] == '0
        |=> rsp.value == Q63_MAX) else $error("long product not saturated");
    mac_corner_a: assert property (taken && req.op == OP_Q15_MAC_LEFT &&
        req.srcA[31:16] == Q15_NEG_ONE && req.srcB[31:16] == Q15_NEG_ONE
        && accBank[req.accumulatorSelect] == '0 |=> rsp.value == Q31_MAX_ACC)
        else $error("q15 product not saturated");
    sat_range_a: assert property (taken && req.op inside {OP_Q15_MAC_SAT_LEFT,
        OP_Q15_MAC_SAT_RIGHT} |=> $signed(rsp.value) <= $signed(Q31_MAX_ACC)
        && $signed(rsp.value) >= $signed(Q31_MIN_ACC)) else $error("sat mac out of range");
    load_value_a: assert property (taken && req.op == OP_ACC_LOAD |=>
        rsp.value == {$past(req.srcA), $past(req.srcB)}) else $error("load value wrong");
    reset_clear_a: assert property (disable iff (1'b0)
        rst |=> accBank == '0 && !rsp.valid)
        else $error("reset did not clear");
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the fractional multiply-accumulate datapath
`default_nettype none
module tb
    import frac_mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    mac_req_t    req;
    mac_rsp_t    rsp;
    acc_bank_t   accBank;
    logic [63:0] mdl [4];
    logic [1:0]  qs [$];
    logic [63:0] qv [$];
    logic [31:0] x = 32'haa8f;
    int          fails = 0;
    int          n_tests = 0;
    always #10 mclk = ~mclk;
    pipeline_model pipe (.mclk(mclk), .req(req));
    fractional_mac_datapath uut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .accBank(accBank));
    // ----------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic longint q15p(logic [15:0] a, logic [15:0] b);
        return (a == Q15_NEG_ONE && b == Q15_NEG_ONE) ? longint'(Q31_MAX)
            : 2 * longint'($signed(a)) * longint'($signed(b));
    endfunction
    function automatic longint q31p(logic [31:0] a, logic [31:0] b);
        return (a == Q31_NEG_ONE && b == Q31_NEG_ONE) ? longint'(Q63_MAX)
            : 2 * longint'($signed(a)) * longint'($signed(b));
    endfunction
    function automatic logic [63:0] expv(mac_op_t op, logic [31:0] a, logic [31:0] b,
                                         logic [63:0] acc);
        longint ph, pl, m;
        logic signed [64:0] s;
        ph = q15p(a[31:16], b[31:16]);
        pl = q15p(a[15:0], b[15:0]);
        m = longint'($signed(a)) * longint'($signed(b));
        if (op inside {OP_UNSIGNED_MUL, OP_UNSIGNED_MUL_ADD, OP_UNSIGNED_MUL_SUB}) begin
            m = {32'h0, a} * b;
        end
        s = $signed({acc[63], acc}) + ((op == OP_Q31_LONG_DOT_SUB) ? -q31p(a, b) : q31p(a, b));
        case (op)
            OP_Q15_PAIR_DOT_ADD: return acc + (ph + pl);
            OP_Q15_PAIR_DOT_SUB: return acc - (ph + pl);
            OP_COMPLEX_MUL_STEP: return acc + (ph - pl);
            OP_Q31_LONG_DOT_ADD, OP_Q31_LONG_DOT_SUB:
                return (s[64] != s[63]) ? (s[64] ? Q63_MIN : Q63_MAX) : s[63:0];
            OP_Q15_MAC_LEFT: return acc + ph;
            OP_Q15_MAC_RIGHT: return acc + pl;
            OP_Q15_MAC_SAT_LEFT, OP_Q15_MAC_SAT_RIGHT: begin
                s = $signed({acc[63], acc}) + ((op == OP_Q15_MAC_SAT_LEFT) ? ph : pl);
                return (s > 65'sd2147483647) ? Q31_MAX_ACC
                    : (s < -65'sd2147483648) ? Q31_MIN_ACC : s[63:0];
            end
            OP_SIGNED_MUL, OP_UNSIGNED_MUL: return m;
            OP_SIGNED_MUL_ADD, OP_UNSIGNED_MUL_ADD: return acc + m;
            OP_SIGNED_MUL_SUB, OP_UNSIGNED_MUL_SUB: return acc - m;
            default: return {a, b};
        endcase
    endfunction
    // ----------------------------------------------------------------
    // checking and stimulus
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input logic v, input mac_op_t op, input logic [1:0] sel,
                       input logic [31:0] a, input logic [31:0] b);
        if (v && op != OP_NOP) begin
            mdl[sel] = expv(op, a, b, mdl[sel]);
            qs.push_back(sel);
            qv.push_back(mdl[sel]);
        end
        pipe.issue(v, op, sel, a, b);
    endtask
    task automatic endTest(input string s);
        run(1'b0, OP_NOP, 2'd0, 32'h0, 32'h0);
        repeat (3) @(negedge mclk);
        check(64'(qv.size()), 64'h0);
        $display("%s done", s);
    endtask
    // negedge sampling keeps the registered result clear of the launching edge
    always @(negedge mclk) if (!rst && rsp.valid !== 1'b0) begin
        if (qv.size() == 0) check(64'h1, 64'h0);
        else begin
            check(rsp.accumulatorSelect, qs.pop_front());
            check(rsp.value, qv[0]);
            check(accBank[rsp.accumulatorSelect], qv.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        summarize();
    end
    initial begin
        logic [31:0] r, a, b;
        mdl = '{default: '0};
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        for (int i = 1; i < 17; i++) begin
            run(1'b1, mac_op_t'(i), 2'(i), 32'h8000_8000, 32'h8000_8000);
            run(1'b1, mac_op_t'(i), 2'(i + 1), Q31_NEG_ONE, Q31_NEG_ONE);
        end
        run(1'b1, OP_ACC_LOAD, 2'd2, 32'h0, 32'h7fff_fff0);
        run(1'b1, OP_Q15_MAC_SAT_RIGHT, 2'd2, 32'h0000_4000, 32'h0000_4000);
        run(1'b1, OP_ACC_LOAD, 2'd3, 32'h8000_0000, 32'h0000_0001);
        run(1'b1, OP_Q31_LONG_DOT_SUB, 2'd3, 32'h4000_0000, 32'h4000_0000);
        run(1'b0, OP_Q15_PAIR_DOT_ADD, 2'd3, 32'h1, 32'h1);
        run(1'b1, OP_NOP, 2'd3, 32'h1, 32'h1);
        endTest("corners");
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            a = (r[9:8] == 2'd0) ? 32'h8000_8000 : rnd();
            b = (r[11:10] == 2'd0) ? 32'h8000_8000 : rnd();
            if (r[13:12] == 2'd0) a = Q31_NEG_ONE;
            run(|r[6:5], mac_op_t'(r[20:16] % 17), r[1:0], a, b);
        end
        endTest("random");
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        mdl = '{default: '0};
        for (int i = 0; i < 4; i++) check(accBank[i], 64'h0);
        run(1'b1, OP_Q15_MAC_LEFT, 2'd0, 32'h8000_0001, 32'h8000_0002);
        run(1'b1, OP_Q31_LONG_DOT_ADD, 2'd1, Q31_NEG_ONE, Q31_NEG_ONE);
        run(1'b1, OP_Q15_PAIR_DOT_ADD, 2'd2, 32'h8000_8000, 32'h8000_8000);
        endTest("reset");
        summarize();
    end
endmodule
bind fractional_mac_datapath frac_mac_assertions chk (.mclk(mclk), .rst(rst), .req(req),
    .rsp(rsp), .accBank(accBank));
`default_nettype wire
